// ---- rtl/bsc_top.sv ----
/*
  Two-wire bus sequence controller: register port on clk, bus engine on link_clk.
  Assumes external pull-ups on both bus lines and a free-running link clock.
*/
`timescale 1ns/1ps
module bsc_top
  import bsc_pkg::*;
#(
  parameter int QTR = QTR_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       link_clk,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wr_data,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  output logic      [7:0] rd_data,
  input  wire logic       scl_in,
  output logic            scl_out,
  output logic            scl_oe_n,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n
);
  if (QTR < 2 || QTR > 255) begin : g_bad_qtr
    $error("QTR must lie in 2..255");
  end

  localparam logic [7:0] QTR_LAST = 8'(QTR - 1);

  // Core clock domain
  logic [4:0]  req_bits_reg;
  logic        gce_reg;
  logic        ack_data_value_reg;
  logic        ack_status_reg;
  logic        master_reg;
  logic        stretch_reg;
  logic        busy_reg;
  logic        req_tog_reg;
  logic        rel_tog_reg;
  logic [7:0]  rx_data_reg;
  logic [7:0]  rd_data_reg;
  bsc_req_type req_reg;
  logic [1:0]  back_s;
  logic        done_pulse;

  // Link clock domain
  bsc_state_type st_reg;
  logic [7:0]  qcnt_reg;
  logic [1:0]  quarter_reg;
  logic [3:0]  bitn_reg;
  logic [7:0]  shift_reg;
  logic        rx_mode_reg;
  logic        own_reg;
  logic        ack_rx_reg;
  logic        sample_reg;
  logic        done_tog_reg;
  logic        hold_reg;
  logic [3:0]  scount_reg;
  logic        scl_prev_reg;
  logic        sda_prev_reg;
  logic        scl_oe_n_reg;
  logic        sda_oe_n_reg;
  logic        line_out_reg;
  logic [5:0]  fwd_s;
  logic        req_pulse;
  logic        rel_pulse;
  bsc_res_type res_reg;

  wire ctrl_wr = wr_en && addr == ADDR_SEQ_CTRL;
  wire buf_wr  = wr_en && addr == ADDR_XFER_BUF;
  wire mode_wr = wr_en && addr == ADDR_MODE;

  wire [4:0] wr_req = wr_data[4:0] & {5{master_reg}};
  // Only the highest-priority request of a write is taken
  wire [4:0] pick = wr_req[START_BIT]  ? 5'h01 :
                    wr_req[RSTART_BIT] ? 5'h02 :
                    wr_req[STOP_BIT]   ? 5'h04 :
                    wr_req[RCV_BIT]    ? 5'h08 :
                    wr_req[ACKREQ_BIT] ? 5'h10 : 5'h00;
  wire accept_seq = ctrl_wr && !busy_reg && (|pick);
  wire accept_tx  = buf_wr && master_reg && !busy_reg;
  wire launch     = accept_seq || accept_tx;
  wire [2:0] cmd_raw = accept_tx  ? CMD_TX     :
                       pick[0]    ? CMD_START  :
                       pick[1]    ? CMD_RSTART :
                       pick[2]    ? CMD_STOP   :
                       pick[3]    ? CMD_RX     : CMD_ACK;
  wire [4:0] req_after_done = master_reg ? REQ_RESET : (req_bits_reg & 5'h01);

  wire [7:0] seq_rd  = {gce_reg, ack_status_reg, ack_data_value_reg, req_bits_reg};
  wire [7:0] mode_rd = {5'h00, busy_reg, !back_s[0], master_reg};
  wire [7:0] rd_mux  = (addr == ADDR_SEQ_CTRL) ? seq_rd  :
                       (addr == ADDR_XFER_BUF) ? rx_data_reg :
                       (addr == ADDR_MODE)     ? mode_rd : 8'h00;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      req_bits_reg <= REQ_RESET;
      gce_reg      <= 1'b0;
      ack_data_value_reg    <= 1'b0;
      master_reg   <= 1'b0;
      stretch_reg  <= 1'b0;
      busy_reg     <= 1'b0;
      req_tog_reg  <= 1'b0;
      rel_tog_reg  <= 1'b0;
      req_reg      <= '0;
      rd_data_reg  <= BYTE_RESET;
    end else begin
      rd_data_reg <= rd_en ? rd_mux : BYTE_RESET;
      stretch_reg <= !master_reg && req_bits_reg[START_BIT];
      if (done_pulse) begin
        req_bits_reg <= req_after_done;
      end else if (ctrl_wr && !busy_reg) begin
        req_bits_reg <= master_reg ? pick : {4'h0, wr_data[START_BIT]};
      end
      if (ctrl_wr) begin
        gce_reg <= wr_data[GCE_BIT];
      end
      if (ctrl_wr && !busy_reg) begin
        ack_data_value_reg <= wr_data[ACK_DATA_VALUE_BIT];
      end
      if (mode_wr && !busy_reg) begin
        master_reg <= wr_data[MODE_MASTER_BIT];
      end
      if (mode_wr && wr_data[MODE_REL_BIT]) begin
        rel_tog_reg <= !rel_tog_reg;
      end
      if (launch) begin
        busy_reg    <= 1'b1;
        req_tog_reg <= !req_tog_reg;
        req_reg     <= '{cmd: bsc_cmd_type'(cmd_raw), tx_data: wr_data,
                         ack_value: accept_seq ? wr_data[ACK_DATA_VALUE_BIT] : ack_data_value_reg};
      end else if (done_pulse) begin
        busy_reg <= 1'b0;
      end
    end
  end

  // Result words are stable in the link domain from the done toggle onward
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_status_reg <= 1'b0;
      rx_data_reg    <= BYTE_RESET;
    end else if (done_pulse && req_reg.cmd == CMD_TX) begin
      ack_status_reg <= res_reg.ack_rx;
    end else if (done_pulse && req_reg.cmd == CMD_RX) begin
      rx_data_reg <= res_reg.rx_data;
    end
  end

  bsc_sync #(.WIDTH(2)) u_back_sync (
    .clk(clk), .reset_n(reset_n), .din({done_tog_reg, hold_reg}), .dout(back_s));
  bsc_edge u_done_edge (
    .clk(clk), .reset_n(reset_n), .level(back_s[1]), .pulse(done_pulse));
  bsc_sync #(.WIDTH(6)) u_fwd_sync (
    .clk(link_clk), .reset_n(reset_n), .din({scl_in, sda_in, master_reg, stretch_reg, req_tog_reg, rel_tog_reg}),
    .dout(fwd_s));
  bsc_edge u_req_edge (
    .clk(link_clk), .reset_n(reset_n), .level(fwd_s[1]), .pulse(req_pulse));
  bsc_edge u_rel_edge (
    .clk(link_clk), .reset_n(reset_n), .level(fwd_s[0]), .pulse(rel_pulse));

  wire scl_s     = fwd_s[5];
  wire sda_s     = fwd_s[4];
  wire master_s  = fwd_s[3];
  wire stretch_s = fwd_s[2];

  // Per-quarter line levels, quarter 0 in bit 0; a 0 pulls the line low
  wire       out_bit = rx_mode_reg || (bitn_reg == TX_LAST_BIT) || shift_reg[7];
  wire [3:0] seq_sda = (st_reg == ST_START)  ? 4'h3 :
                       (st_reg == ST_RSTART) ? 4'h3 :
                       (st_reg == ST_STOP)   ? 4'hc :
                       (st_reg == ST_XFER)   ? {4{out_bit}} :
                       (st_reg == ST_ACK)    ? {4{req_reg.ack_value}} : 4'hf;
  wire [3:0] seq_scl = (st_reg == ST_START)  ? 4'h7 :
                       (st_reg == ST_STOP)   ? 4'he :
                       (st_reg == ST_IDLE)   ? {4{!own_reg}} : 4'h6;
  // A slave holding the clock low stretches the high quarters
  wire stall    = scl_oe_n_reg && !scl_s && (st_reg != ST_IDLE);
  wire tick     = (qcnt_reg == QTR_LAST) && !stall;
  wire last_bit = (st_reg != ST_XFER) || (bitn_reg == (rx_mode_reg ? RX_LAST_BIT : TX_LAST_BIT));
  wire scl_fall = scl_prev_reg && !scl_s;
  wire start_det = scl_s && sda_prev_reg && !sda_s;
  bsc_state_type st_launch;
  assign st_launch = (req_reg.cmd == CMD_START)  ? ST_START  :
                     (req_reg.cmd == CMD_RSTART) ? ST_RSTART :
                     (req_reg.cmd == CMD_STOP)   ? ST_STOP   :
                     (req_reg.cmd == CMD_ACK)    ? ST_ACK    : ST_XFER;

  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg       <= ST_IDLE;
      qcnt_reg     <= 8'h00;
      quarter_reg  <= 2'h0;
      bitn_reg     <= 4'h0;
      shift_reg    <= BYTE_RESET;
      rx_mode_reg  <= 1'b0;
      own_reg      <= 1'b0;
      ack_rx_reg   <= 1'b0;
      sample_reg   <= 1'b0;
      done_tog_reg <= 1'b0;
    end else begin
      unique case (st_reg)
        ST_IDLE: begin
          if (req_pulse && master_s) begin
            st_reg      <= st_launch;
            shift_reg   <= req_reg.tx_data;
            rx_mode_reg <= req_reg.cmd == CMD_RX;
            qcnt_reg    <= 8'h00;
            quarter_reg <= 2'h0;
            bitn_reg    <= 4'h0;
          end else if (req_pulse) begin
            done_tog_reg <= !done_tog_reg;
          end
        end
        ST_START, ST_RSTART, ST_STOP, ST_XFER, ST_ACK: begin
          if (!stall) begin
            qcnt_reg <= tick ? 8'h00 : qcnt_reg + 8'h01;
          end
          if (tick && quarter_reg == 2'h1 && st_reg == ST_XFER) begin
            if (bitn_reg == TX_LAST_BIT) begin
              ack_rx_reg <= sda_s;
            end else begin
              sample_reg <= sda_s;
            end
          end
          // Shift only at the end of the low quarter so SDA never moves while SCL is high
          if (tick && quarter_reg == 2'h3 && st_reg == ST_XFER && bitn_reg != TX_LAST_BIT) begin
            shift_reg <= {shift_reg[6:0], sample_reg};
          end
          if (tick) begin
            quarter_reg <= quarter_reg + 2'h1;
          end
          if (tick && quarter_reg == 2'h3) begin
            if (last_bit) begin
              st_reg       <= ST_IDLE;
              own_reg      <= st_reg != ST_STOP;
              done_tog_reg <= !done_tog_reg;
            end else begin
              bitn_reg <= bitn_reg + 4'h1;
            end
          end
        end
      endcase
    end
  end

  assign res_reg = '{rx_data: shift_reg, ack_rx: ack_rx_reg};

  // Slave side: count clocks from a Start, hold SCL after each ninth
  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      hold_reg     <= 1'b0;
      scount_reg   <= 4'h0;
      scl_prev_reg <= 1'b0;
      sda_prev_reg <= 1'b0;
      scl_oe_n_reg <= 1'b1;
      sda_oe_n_reg <= 1'b1;
      line_out_reg <= 1'b0;
    end else begin
      scl_prev_reg <= scl_s;
      sda_prev_reg <= sda_s;
      scl_oe_n_reg <= seq_scl[quarter_reg] && !hold_reg;
      sda_oe_n_reg <= seq_sda[quarter_reg];
      if (master_s) begin
        scount_reg <= 4'h0;
      end else if (start_det) begin
        // All ones, so the fall that ends the Start wraps to zero and is not counted
        scount_reg <= '1;
      end else if (scl_fall) begin
        scount_reg <= (scount_reg == SLV_LAST_BIT) ? 4'h0 : scount_reg + 4'h1;
      end
      // A new stretch wins over a release arriving in the same cycle
      if (scl_fall && !master_s && stretch_s && scount_reg == SLV_LAST_BIT) begin
        hold_reg <= 1'b1;
      end else if (rel_pulse || master_s) begin
        hold_reg <= 1'b0;
      end
    end
  end

  assign rd_data  = rd_data_reg;
  assign scl_out  = line_out_reg;
  assign sda_out  = line_out_reg;
  assign scl_oe_n = scl_oe_n_reg;
  assign sda_oe_n = sda_oe_n_reg;

  property p_busy_ignore;
    @(posedge clk) disable iff (!reset_n)
    (ctrl_wr && busy_reg && !done_pulse) |=> (req_bits_reg == $past(req_bits_reg));
  endproperty
  a_busy_ignore: assert property (p_busy_ignore) else $error("request taken while busy");
  property p_auto_clear;
    @(posedge clk) disable iff (!reset_n)
    (done_pulse && master_reg) |=> (req_bits_reg == 5'h00) && !busy_reg;
  endproperty
  a_auto_clear: assert property (p_auto_clear) else $error("request bit not cleared");
  property p_stop_launch;
    @(posedge clk) disable iff (!reset_n)
    (accept_seq && pick == 5'h04) |=> (req_reg.cmd == CMD_STOP) && (req_tog_reg != $past(req_tog_reg));
  endproperty
  a_stop_launch: assert property (p_stop_launch) else $error("stop not launched");
  property p_rstart_launch;
    @(posedge clk) disable iff (!reset_n)
    (accept_seq && pick == 5'h02) |=> (req_reg.cmd == CMD_RSTART) ##1 busy_reg;
  endproperty
  a_rstart_launch: assert property (p_rstart_launch) else $error("repeated start not launched");
  property p_ack_status;
    @(posedge clk) disable iff (!reset_n)
    (done_pulse && req_reg.cmd == CMD_TX) |=> (ack_status_reg == $past(res_reg.ack_rx));
  endproperty
  a_ack_status: assert property (p_ack_status) else $error("ack status not recorded");
  property p_ack_drive;
    @(posedge link_clk) disable iff (!reset_n)
    (st_reg == ST_ACK && $past(st_reg) == ST_ACK) |-> (sda_oe_n_reg == req_reg.ack_value);
  endproperty
  a_ack_drive: assert property (p_ack_drive) else $error("wrong acknowledge level");
  property p_stop_end;
    @(posedge link_clk) disable iff (!reset_n)
    (st_reg == ST_STOP && tick && quarter_reg == 2'h3) |=> ##1 (sda_oe_n_reg && scl_oe_n_reg);
  endproperty
  a_stop_end: assert property (p_stop_end) else $error("bus not free after stop");
  property p_hold_scl;
    @(posedge link_clk) disable iff (!reset_n)
    hold_reg |=> !scl_oe_n_reg;
  endproperty
  a_hold_scl: assert property (p_hold_scl) else $error("stretch not holding clock");
  property p_hold_keep;
    @(posedge link_clk) disable iff (!reset_n)
    (hold_reg && !rel_pulse && !master_s) |=> hold_reg;
  endproperty
  a_hold_keep: assert property (p_hold_keep) else $error("stretch released early");
  c_tx_done:  cover property (@(posedge clk) done_pulse && req_reg.cmd == CMD_TX);
  c_rx_done:  cover property (@(posedge clk) done_pulse && req_reg.cmd == CMD_RX);
  c_busy_wr:  cover property (@(posedge clk) ctrl_wr && busy_reg);
  c_stretch:  cover property (@(posedge link_clk) $rose(hold_reg));
endmodule : bsc_top

// ---- rtl/bsc_pkg.sv ----
/*
  Constants, types and field layout of the two-wire bus sequence controller.
  Assumes a core clock of 20 MHz and a separate free-running link clock of 160 ns.
*/
// Overview of operation
// - Acknowledge data bit 5: 1 sends NACK
// - Stop request bit 2 generates Stop
// - Repeated-start request bit 1 generates Repeated Start
// - Hardware clears request bits when done
// - Requests while busy are ignored, not queued
// - Acknowledge sequence sends the acknowledge data bit
// - Slave stretch holds clock until release
package bsc_pkg;

  localparam logic [7:0] ADDR_SEQ_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_XFER_BUF   = 8'h01;
  localparam logic [7:0] ADDR_MODE       = 8'h02;

  localparam int         GCE_BIT         = 7;
  localparam int         ACK_STATUS_BIT     = 6;
  localparam int         ACK_DATA_VALUE_BIT       = 5;
  localparam int         ACKREQ_BIT      = 4;
  localparam int         RCV_BIT         = 3;
  localparam int         STOP_BIT        = 2;
  localparam int         RSTART_BIT      = 1;
  localparam int         START_BIT       = 0;
  localparam int         MODE_MASTER_BIT = 0;
  localparam int         MODE_REL_BIT    = 1;

  localparam logic [4:0] REQ_RESET       = 5'h00;
  localparam logic [7:0] BYTE_RESET      = 8'h00;

  localparam int         BIT_TIME_NS     = 10000;
  localparam int         LINK_PERIOD_NS  = 160;
  localparam int         QTR_CYCLES      = BIT_TIME_NS / (4 * LINK_PERIOD_NS);
  localparam logic [3:0] TX_LAST_BIT     = 4'h8;
  localparam logic [3:0] RX_LAST_BIT     = 4'h7;
  localparam logic [3:0] SLV_LAST_BIT    = 4'h8;

  typedef enum logic [2:0] {
    CMD_NONE   = 3'h0,
    CMD_START  = 3'h1,
    CMD_RSTART = 3'h2,
    CMD_STOP   = 3'h3,
    CMD_RX     = 3'h4,
    CMD_ACK    = 3'h5,
    CMD_TX     = 3'h6
  } bsc_cmd_type;

  typedef enum logic [5:0] {
    ST_IDLE   = 6'h01,
    ST_START  = 6'h02,
    ST_RSTART = 6'h04,
    ST_STOP   = 6'h08,
    ST_XFER   = 6'h10,
    ST_ACK    = 6'h20
  } bsc_state_type;

  typedef struct packed {
    bsc_cmd_type cmd;
    logic [7:0]  tx_data;
    logic        ack_value;
  } bsc_req_type;

  typedef struct packed {
    logic [7:0] rx_data;
    logic       ack_rx;
  } bsc_res_type;

endpackage : bsc_pkg

// ---- rtl/bsc_sync.sv ----
/*
  Two flip-flop level synchroniser, WIDTH bits wide.
  Assumes each bit is a level that changes far slower than the receiving clock.
*/
`timescale 1ns/1ps
module bsc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_reg <= '0;
      dout     <= '0;
    end else begin
      meta_reg <= din;
      dout     <= meta_reg;
    end
  end
endmodule : bsc_sync

// ---- rtl/bsc_edge.sv ----
/*
  Change detector: one-cycle pulse whenever a synchronised toggle flips.
  Assumes its input already passed a synchroniser in this clock's domain.
*/
`timescale 1ns/1ps
module bsc_edge (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic level,
  output logic      pulse
);
  logic last_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      last_reg <= 1'b0;
    end else begin
      last_reg <= level;
    end
  end

  assign pulse = level ^ last_reg;
endmodule : bsc_edge

// ---- verif/bsc_bus_slave.sv ----
/*
  Behavioural slave on the two-wire bus: takes or sends one byte, acknowledges on request.
  Assumes the bench resolves both open-drain lines with pull-ups.
*/
`timescale 1ns/1ps
module bsc_bus_slave (
  input  wire logic       sda,
  input  wire logic       scl,
  input  wire logic       ack_en,
  input  wire logic       send_en,
  input  wire logic [7:0] send_byte,
  input  wire logic       slow,
  output logic            sda_oe_n,
  output logic            scl_oe_n,
  output logic [7:0]      got_byte,
  output logic            got_ack
);
  int n_bit;

  initial begin
    sda_oe_n = 1'h1;
    scl_oe_n = 1'h1;
    got_byte = 8'h00;
    got_ack  = 1'h1;
    n_bit    = 0;
  end

  // Start, repeated start and stop all restart the bit count
  always @(sda) if (scl === 1'h1) n_bit = 0;

  always @(posedge scl) begin
    n_bit = n_bit + 1;
    if (n_bit <= 8) got_byte = {got_byte[6:0], sda};
    else got_ack = sda;
  end

  // Data only changes while SCL is low; slow mode stretches every low phase
  always @(negedge scl or posedge send_en) begin
    if (n_bit == 9) n_bit = 0;
    sda_oe_n = 1'h1;
    if (send_en && n_bit < 8) sda_oe_n = send_byte[7 - n_bit];
    if (ack_en && !send_en && n_bit == 8) sda_oe_n = 1'h0;
  end

  // The stretch runs in its own process so a held clock never hides a data event
  always @(negedge scl) begin
    if (slow) begin
      scl_oe_n = 1'h0;
      #1500;
      scl_oe_n = 1'h1;
    end
  end
endmodule : bsc_bus_slave

// ---- verif/tb_i2c_master_sequence_control.sv ----
/*
  Self-checking bench for bsc_top: register port, master sequences, slave stretch.
  Assumes bsc_bus_slave on the bus; the bench acts as an outside master for stretching.
*/
`timescale 1ns/1ps
module tb_i2c_master_sequence_control
  import bsc_pkg::*;
();
  logic       clk, reset_n, link_clk, wr_en, rd_en;
  logic [7:0] addr, wr_data, rd_data, slv_byte, got_byte;
  logic       scl_out, scl_oe_n, sda_out, sda_oe_n, got_ack;
  logic       ext_sda_n, ext_scl_n, slv_ack, slv_send, slv_slow, slv_sda_n, slv_scl_n;
  wire        sda_w = (sda_oe_n !== 1'h0) & slv_sda_n & ext_sda_n;
  wire        scl_w = (scl_oe_n !== 1'h0) & slv_scl_n & ext_scl_n;
  int         n_mismatch, samples_checked, n_start, n_stop, s0;

  bsc_top #(.QTR(2)) i_dut (
    .clk(clk), .reset_n(reset_n), .link_clk(link_clk), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .scl_in(scl_w), .scl_out(scl_out),
    .scl_oe_n(scl_oe_n), .sda_in(sda_w), .sda_out(sda_out), .sda_oe_n(sda_oe_n));

  bsc_bus_slave i_slave (
    .sda(sda_w), .scl(scl_w), .ack_en(slv_ack), .send_en(slv_send), .send_byte(slv_byte),
    .slow(slv_slow), .sda_oe_n(slv_sda_n), .scl_oe_n(slv_scl_n), .got_byte(got_byte),
    .got_ack(got_ack));

  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  initial begin
    link_clk = 1'h0;
    #37;
    forever #80 link_clk = ~link_clk;
  end

  always @(negedge sda_w) if (scl_w === 1'h1) n_start++;
  always @(posedge sda_w) if (scl_w === 1'h1) n_stop++;

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    wr_en   <= 1'h1;
    addr    <= a;
    wr_data <= v;
    @(posedge clk);
    wr_en <= 1'h0;
    @(posedge clk);
  endtask : wr

  task automatic rdchk(input string what, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd_en <= 1'h1;
    addr  <= a;
    @(posedge clk);
    rd_en <= 1'h0;
    @(negedge clk);
    v = rd_data;
    chk(what, exp, v);
    @(posedge clk);
  endtask : rdchk

  // Polls busy through the mode register; a stuck busy ends the run instead of hanging
  task automatic wait_idle();
    for (int i = 0; i < 3000; i++) begin
      rd_en <= 1'h1;
      addr  <= ADDR_MODE;
      @(posedge clk);
      rd_en <= 1'h0;
      @(negedge clk);
      if (rd_data[2] === 1'h0) begin
        @(posedge clk);
        return;
      end
      @(posedge clk);
    end
    n_mismatch++;
    $display("mismatch busy expected 0 seen 1");
    report_and_stop();
  endtask : wait_idle

  task automatic ext_ph(input logic s, input logic c);
    ext_sda_n <= s;
    ext_scl_n <= c;
    repeat (20) @(posedge clk);
  endtask : ext_ph

  task automatic t_reset();
    chk("oe_n", 8'h03, {6'h00, sda_oe_n, scl_oe_n});
    chk("outs", 8'h00, {6'h00, sda_out, scl_out});
    rdchk("seq reset", ADDR_SEQ_CTRL, 8'h00);
    rdchk("mode reset", ADDR_MODE, 8'h02);
    rdchk("unmapped", 8'h07, 8'h00);
    wr(ADDR_SEQ_CTRL, 8'h84);
    rdchk("slave seq", ADDR_SEQ_CTRL, 8'h80);
    wr(ADDR_SEQ_CTRL, 8'h00);
    $display("test reset done");
  endtask : t_reset

  task automatic t_start();
    wr(ADDR_MODE, 8'h01);
    rdchk("master", ADDR_MODE, 8'h03);
    s0 = n_start;
    wr(ADDR_SEQ_CTRL, 8'h01);
    rdchk("start set", ADDR_SEQ_CTRL, 8'h01);
    wait_idle();
    rdchk("start clear", ADDR_SEQ_CTRL, 8'h00);
    chk("starts", 8'h01, 8'(n_start - s0));
    $display("test start done");
  endtask : t_start

  task automatic tx(input logic [7:0] b, input logic [7:0] exp_seq);
    wr(ADDR_XFER_BUF, b);
    wait_idle();
    chk("tx byte", b, got_byte);
    rdchk("ack status", ADDR_SEQ_CTRL, exp_seq);
  endtask : tx

  task automatic t_tx();
    slv_ack <= 1'h1;
    wr(ADDR_XFER_BUF, 8'ha5);
    wr(ADDR_SEQ_CTRL, 8'h24);
    wr(ADDR_XFER_BUF, 8'hff);
    wait_idle();
    chk("tx byte", 8'ha5, got_byte);
    repeat (40) @(posedge clk);
    rdchk("no queued op", ADDR_MODE, 8'h03);
    rdchk("busy writes", ADDR_SEQ_CTRL, 8'h00);
    slv_ack <= 1'h0;
    tx(8'h3c, 8'h40);
    slv_ack  <= 1'h1;
    slv_slow <= 1'h1;
    tx(8'h96, 8'h00);
    slv_slow <= 1'h0;
    $display("test transmit done");
  endtask : t_tx

  task automatic rx_ack(input logic [7:0] b, input logic [7:0] cmd, input logic ack_exp);
    slv_byte <= b;
    slv_send <= 1'h1;
    wr(ADDR_SEQ_CTRL, 8'h08);
    rdchk("rx set", ADDR_SEQ_CTRL, 8'h08);
    wait_idle();
    rdchk("rx byte", ADDR_XFER_BUF, b);
    wr(ADDR_SEQ_CTRL, cmd);
    slv_send <= 1'h0;
    wait_idle();
    chk("ack sent", {7'h00, ack_exp}, {7'h00, got_ack});
    rdchk("ack clear", ADDR_SEQ_CTRL, cmd & 8'h20);
  endtask : rx_ack

  task automatic t_seq();
    rx_ack(8'hc3, 8'h10, 1'h0);
    rx_ack(8'h5e, 8'h30, 1'h1);
    s0 = n_start;
    wr(ADDR_SEQ_CTRL, 8'h22);
    rdchk("rstart set", ADDR_SEQ_CTRL, 8'h22);
    wait_idle();
    rdchk("rstart clear", ADDR_SEQ_CTRL, 8'h20);
    chk("rstarts", 8'h01, 8'(n_start - s0));
    s0 = n_stop;
    wr(ADDR_SEQ_CTRL, 8'h0c);
    rdchk("stop set", ADDR_SEQ_CTRL, 8'h04);
    wait_idle();
    rdchk("stop clear", ADDR_SEQ_CTRL, 8'h00);
    chk("stops", 8'h01, 8'(n_stop - s0));
    chk("idle lines", 8'h03, {6'h00, sda_w, scl_w});
    $display("test sequences done");
  endtask : t_seq

  task automatic t_stretch();
    int i;
    slv_ack <= 1'h0;
    wr(ADDR_MODE, 8'h00);
    wr(ADDR_SEQ_CTRL, 8'h01);
    rdchk("stretch en", ADDR_SEQ_CTRL, 8'h01);
    ext_ph(1'h0, 1'h1);
    ext_ph(1'h0, 1'h0);
    for (i = 0; i < 9; i++) begin
      ext_ph(1'h1, 1'h1);
      chk("pulse scl", 8'h01, {7'h00, scl_w});
      ext_ph(1'h1, 1'h0);
    end
    ext_ph(1'h0, 1'h1);
    chk("held scl", 8'h00, {7'h00, scl_w});
    rdchk("held", ADDR_MODE, 8'h00);
    wr(ADDR_MODE, 8'h02);
    for (i = 0; i < 100 && scl_w !== 1'h1; i++) @(posedge clk);
    chk("released scl", 8'h01, {7'h00, scl_w});
    ext_ph(1'h1, 1'h1);
    $display("test stretch done");
  endtask : t_stretch

  initial begin
    reset_n         = 1'h0;
    wr_en           = 1'h0;
    rd_en           = 1'h0;
    addr            = 8'h00;
    wr_data         = 8'h00;
    ext_sda_n       = 1'h1;
    ext_scl_n       = 1'h1;
    slv_ack         = 1'h0;
    slv_send        = 1'h0;
    slv_slow        = 1'h0;
    slv_byte        = 8'h00;
    n_mismatch      = 0;
    samples_checked = 0;
    repeat (10) @(posedge clk);
    reset_n <= 1'h1;
    repeat (8) @(posedge clk);
    t_reset();
    t_start();
    t_tx();
    t_seq();
    t_stretch();
    report_and_stop();
  end
endmodule : tb_i2c_master_sequence_control
